/* File: sal_dev.sv */
// Device end: banked and secure-only registers, non-secure filtering and
// configuration lockdown of a small interrupt distributor and CPU interface.
// Assumes word accesses over the link, one request at a time.
`timescale 1ns/10ps
module sal_dev
#(
  parameter int          NUM_IRQ   = 64,
  parameter int          LOCKABLE_COUNT_FIELD_NUM  = 31,
  parameter logic [63:0] FIXED_MSK = 64'h0,
  parameter logic [63:0] FIXED_VAL = 64'h0
)
(
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // Link
  sal_if.dev        link
);
  import sal_pkg::*;

  typedef struct packed {
    logic                    ack;
    logic [31:0]             rdata;
    logic                    dcr_s;
    logic                    dcr_ns;
    logic [ICR_S_W-1:0]      icr_s;
    logic                    icr_ns;
    logic [2:0]              bpr_s;
    logic [2:0]              bpr_ns;
    logic [7:0]              pmr;
    logic [NUM_IRQ-1:0]      isec;
    logic [NUM_IRQ-1:0]      ien;
    logic [NUM_IRQ-1:0]      ipend;
    logic [NUM_IRQ-1:0][7:0] prio;
    logic [NUM_IRQ-1:0][7:0] targ;
    logic [NUM_IRQ-1:0][1:0] cfg;
  } sal_dev_state_t;

  sal_dev_state_t s_reg;
  sal_dev_state_t s_next;

  // Lockdown acts only when lockable interrupts exist
  logic locked;
  assign locked = link.lockdown & (LOCKABLE_COUNT_FIELD_NUM != 0);

  // True when the offset addresses the word that holds interrupt i
  function automatic logic hit(input logic [11:0] off, input logic [11:0] base,
                               input int i, input int per);
    hit = ({20'h0, off} == {20'h0, base} + (i / per) * 4);
  endfunction

  // Interrupt in the lockable range
  function automatic logic lockable(input int i);
    lockable = (LOCKABLE_COUNT_FIELD_NUM != 0) && (i >= LOCKABLE_COUNT_FIELD_BASE) && (i <= LOCKABLE_COUNT_FIELD_BASE - 1 + LOCKABLE_COUNT_FIELD_NUM);
  endfunction

  logic        acc;
  logic        wr;
  logic        sreq;
  logic        cpu;
  logic [11:0] off;
  logic [31:0] wd;
  assign acc  = link.req & ~s_reg.ack;
  assign wr   = acc & link.wr;
  assign sreq = link.sec;
  assign cpu  = link.addr[CPU_SEL_BIT];
  assign off  = link.addr[11:0];
  assign wd   = link.wdata;

  // Access decode, filtering and update
  always_comb
  begin
    logic [31:0] rd;
    logic        vis;
    logic        wok;
    int          b;
    rd       = 32'h0;
    vis      = 1'b0;
    wok      = 1'b0;
    b        = 0;
    s_next   = s_reg;
    s_next.ack = acc;
    if (!cpu)
    begin
      // Distributor control, banked
      if (off == OFF_DIST_CTL)
      begin
        rd[0] = sreq ? s_reg.dcr_s : s_reg.dcr_ns;
        if (wr && sreq && !locked)
          s_next.dcr_s = wd[0];
        else if (wr && !sreq)
          s_next.dcr_ns = wd[0];
      end
      // Type register, read only
      if (off == OFF_TYPE)
      begin
        rd[4:0]           = 5'((NUM_IRQ / 32) - 1);
        rd[TYPE_SEC_POS]  = 1'b1;
        rd[TYPE_LOCKABLE_COUNT_FIELD_POS +: 5] = 5'(LOCKABLE_COUNT_FIELD_NUM);
      end
      // Per-interrupt fields
      for (int i = 0; i < NUM_IRQ; i++)
      begin
        vis = sreq | ~s_reg.isec[i];
        wok = vis & ~(locked & lockable(i) & s_reg.isec[i]);
        b   = i % 32;
        if (hit(off, OFF_SECURITY, i, 32))
        begin
          rd[b] = sreq & s_reg.isec[i];
          if (wr && sreq && !FIXED_MSK[i] && !(locked && lockable(i) && s_reg.isec[i]))
            s_next.isec[i] = wd[b];
        end
        if (hit(off, OFF_SET_EN, i, 32) || hit(off, OFF_CLR_EN, i, 32))
        begin
          rd[b] = vis & s_reg.ien[i];
          if (wr && wok && wd[b])
            s_next.ien[i] = hit(off, OFF_SET_EN, i, 32);
        end
        if (hit(off, OFF_SET_PEND, i, 32) || hit(off, OFF_CLR_PEND, i, 32))
        begin
          rd[b] = vis & s_reg.ipend[i];
          if (wr && wok && wd[b])
            s_next.ipend[i] = hit(off, OFF_SET_PEND, i, 32);
        end
        if (hit(off, OFF_PRIO, i, 4))
        begin
          // Non-secure view: value shifted, top bit forced
          if (vis)
            rd[(i % 4) * 8 +: 8] = sreq ? s_reg.prio[i] : {s_reg.prio[i][6:0], 1'b0};
          if (wr && wok)
            s_next.prio[i] = sreq ? wd[(i % 4) * 8 +: 8]
                                  : {1'b1, wd[(i % 4) * 8 + 1 +: 7]};
        end
        if (hit(off, OFF_TARGET, i, 4))
        begin
          if (vis)
            rd[(i % 4) * 8 +: 8] = s_reg.targ[i];
          if (wr && wok)
            s_next.targ[i] = wd[(i % 4) * 8 +: 8];
        end
        if (hit(off, OFF_CONFIG, i, 16))
        begin
          if (vis)
            rd[(i % 16) * 2 +: 2] = s_reg.cfg[i];
          if (wr && wok)
            s_next.cfg[i] = wd[(i % 16) * 2 +: 2];
        end
      end
    end
    else
    begin
      unique case (off)
        // CPU control, banked; lock spares group enable
        OFF_CPU_CTL:
        begin
          rd = sreq ? {27'h0, s_reg.icr_s} : {31'h0, s_reg.icr_ns};
          if (wr && sreq && !locked)
            s_next.icr_s = wd[ICR_S_W-1:0];
          else if (wr && sreq)
            s_next.icr_s[ICR_NS_EN_POS] = wd[ICR_NS_EN_POS];
          else if (wr)
            s_next.icr_ns = wd[0];
        end
        // Priority mask, non-secure view only while high
        OFF_PRIO_MASK:
        begin
          if (sreq)
            rd[7:0] = s_reg.pmr;
          else if (s_reg.pmr[7])
            rd[7:0] = {s_reg.pmr[6:0], 1'b0};
          if (wr && sreq)
            s_next.pmr = wd[7:0];
          else if (wr && s_reg.pmr[7])
            s_next.pmr = {1'b1, wd[7:1]};
        end
        // Binary point, banked
        OFF_BIN_POINT:
        begin
          rd[2:0] = sreq ? s_reg.bpr_s : s_reg.bpr_ns;
          if (wr && sreq)
            s_next.bpr_s = wd[2:0];
          else if (wr)
            s_next.bpr_ns = wd[2:0];
        end
        // Running priority, hidden from non-secure reads while mask is low
        OFF_RUN_PRIO:
        begin
          if (sreq)
            rd[7:0] = RUN_PRIO_IDLE;
          else if (s_reg.pmr[7])
            rd[7:0] = {RUN_PRIO_IDLE[6:0], 1'b0};
        end
        // Alias of the non-secure binary point, secure only
        OFF_ALIAS_BP:
        begin
          rd[2:0] = sreq ? s_reg.bpr_ns : 3'h0;
          if (wr && sreq)
            s_next.bpr_ns = wd[2:0];
        end
        default: ;
      endcase
    end
    s_next.rdata = acc ? rd : s_reg.rdata;
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_reg        <= '0;
      s_reg.isec   <= FIXED_VAL[NUM_IRQ-1:0];
      s_reg.pmr    <= PMR_RESET;
      s_reg.bpr_s  <= BPR_RESET;
      s_reg.bpr_ns <= BPR_RESET;
    end
    else if (i_ce)
      s_reg <= s_next;
  end

  // Outputs
  assign link.ack   = s_reg.ack;
  assign link.rdata = s_reg.rdata;
endmodule

/* File: sal_pkg.sv */
// Constants for the secure access and lockdown register front end.
// Assumes byte offsets on the link; CPU interface block sits at 0x1000.
package sal_pkg;
  // Link address width and block select
  localparam int          ADDR_W        = 13;
  localparam int          CPU_SEL_BIT   = 12;
  // Distributor offsets
  localparam logic [11:0] OFF_DIST_CTL  = 12'h000;
  localparam logic [11:0] OFF_TYPE      = 12'h004;
  localparam logic [11:0] OFF_SECURITY  = 12'h080;
  localparam logic [11:0] OFF_SET_EN    = 12'h100;
  localparam logic [11:0] OFF_CLR_EN    = 12'h180;
  localparam logic [11:0] OFF_SET_PEND  = 12'h200;
  localparam logic [11:0] OFF_CLR_PEND  = 12'h280;
  localparam logic [11:0] OFF_PRIO      = 12'h400;
  localparam logic [11:0] OFF_TARGET    = 12'h800;
  localparam logic [11:0] OFF_CONFIG    = 12'hc00;
  // CPU interface offsets
  localparam logic [11:0] OFF_CPU_CTL   = 12'h000;
  localparam logic [11:0] OFF_PRIO_MASK = 12'h004;
  localparam logic [11:0] OFF_BIN_POINT = 12'h008;
  localparam logic [11:0] OFF_RUN_PRIO  = 12'h014;
  localparam logic [11:0] OFF_ALIAS_BP  = 12'h01c;
  // Type register fields
  localparam int          TYPE_LOCKABLE_COUNT_FIELD_POS = 11;
  localparam int          TYPE_SEC_POS  = 10;
  // Secure CPU control: bit position and field width
  localparam int          ICR_NS_EN_POS = 1;
  localparam int          ICR_S_W       = 5;
  // Reset and idle values
  localparam logic [7:0]  RUN_PRIO_IDLE = 8'hff;
  localparam logic [7:0]  PMR_RESET     = 8'h00;
  localparam logic [2:0]  BPR_RESET     = 3'h0;
  // First lockable interrupt number
  localparam int          LOCKABLE_COUNT_FIELD_BASE     = 32;
  // Host side Avalon register offsets (word index)
  localparam logic [2:0]  HOST_ADDR     = 3'h0;
  localparam logic [2:0]  HOST_WDATA    = 3'h1;
  localparam logic [2:0]  HOST_CTRL     = 3'h2;
  localparam logic [2:0]  HOST_STATUS   = 3'h3;
  localparam logic [2:0]  HOST_RDATA    = 3'h4;
  // Host control bits
  localparam int          CTRL_WR_POS   = 0;
  localparam int          CTRL_SEC_POS  = 1;
  localparam int          CTRL_GO_POS   = 2;
  localparam int          CTRL_LOCK_POS = 3;
endpackage

/* File: sal_if.sv */
// Link between the access requester and the register front end.
// Both ends run on one clock; the bench joins them through this interface.
`timescale 1ns/10ps
interface sal_if;
  import sal_pkg::*;
  logic              req;      // Access request, held until ack
  logic              wr;       // 1 write, 0 read
  logic              sec;      // Security attribute of the access
  logic [ADDR_W-1:0] addr;     // Byte address, word aligned
  logic [31:0]       wdata;
  logic              ack;      // One-cycle answer pulse
  logic [31:0]       rdata;    // Valid with ack
  logic              lockdown; // Configuration lockdown level
  modport dev  (input req, wr, sec, addr, wdata, lockdown, output ack, rdata);
  modport host (output req, wr, sec, addr, wdata, lockdown, input ack, rdata);
endinterface

/* File: sal_host.sv */
// Requester end: Avalon-MM slave registers that issue tagged link accesses.
// Assumes the device answers every request with one ack pulse.
`timescale 1ns/10ps
module sal_host
(
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Avalon-MM slave
  input  wire logic [2:0]  i_av_address,
  input  wire logic        i_av_read,
  input  wire logic        i_av_write,
  input  wire logic [31:0] i_av_writedata,
  output logic      [31:0] o_av_readdata,
  output logic             o_av_waitrequest,
  // Link
  sal_if.host              link
);
  import sal_pkg::*;

  typedef struct packed {
    logic              req;
    logic              wr;
    logic              sec;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic              lock;
    logic              av_ack;
    logic [31:0]       av_rdata;
  } sal_host_state_t;

  sal_host_state_t s_reg;
  sal_host_state_t s_next;

  // Bus answers one cycle after the request appears
  always_comb
  begin
    s_next        = s_reg;
    s_next.av_ack = (i_av_read | i_av_write) & ~s_reg.av_ack;
    if (i_av_read & ~s_reg.av_ack)
    begin
      unique case (i_av_address)
        HOST_ADDR:   s_next.av_rdata = {{(32-ADDR_W){1'b0}}, s_reg.addr};
        HOST_WDATA:  s_next.av_rdata = s_reg.wdata;
        HOST_STATUS: s_next.av_rdata = {30'h0, s_reg.lock, s_reg.req};
        HOST_RDATA:  s_next.av_rdata = s_reg.rdata;
        default:     s_next.av_rdata = 32'h0;
      endcase
    end
    // Writes take effect on the edge where waitrequest is low
    if (i_av_write & s_reg.av_ack)
    begin
      unique case (i_av_address)
        HOST_ADDR:  s_next.addr  = i_av_writedata[ADDR_W-1:0];
        HOST_WDATA: s_next.wdata = i_av_writedata;
        HOST_CTRL:
        begin
          if (i_av_writedata[CTRL_GO_POS] & ~s_reg.req)
          begin
            s_next.req = 1'b1;
            s_next.wr  = i_av_writedata[CTRL_WR_POS];
            s_next.sec = i_av_writedata[CTRL_SEC_POS];
          end
          // Lockdown only rises; only reset drops it
          if (i_av_writedata[CTRL_LOCK_POS])
            s_next.lock = 1'b1;
        end
        default: ;
      endcase
    end
    // Request drops on the answer
    if (s_reg.req & link.ack)
    begin
      s_next.req = 1'b0;
      if (!s_reg.wr)
        s_next.rdata = link.rdata;
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s_reg <= '0;
    else if (i_ce)
      s_reg <= s_next;
  end

  // Outputs
  assign o_av_readdata    = s_reg.av_rdata;
  assign o_av_waitrequest = (i_av_read | i_av_write) & ~s_reg.av_ack;
  assign link.req         = s_reg.req;
  assign link.wr          = s_reg.wr;
  assign link.sec         = s_reg.sec;
  assign link.addr        = s_reg.addr;
  assign link.wdata       = s_reg.wdata;
  assign link.lockdown    = s_reg.lock;
endmodule

/* File: sal_asserts.sv */
// Link checker for the secure access and lockdown front end.
// Assumes one outstanding request, with its fields held through ack.
`timescale 1ns/10ps
module sal_asserts
#(
  parameter int LOCKABLE_COUNT_FIELD_NUM = 31
)
(
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // Link
  input  wire logic                       req,
  input  wire logic                       wr,
  input  wire logic                       sec,
  input  wire logic [sal_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       ack,
  input  wire logic [31:0]                rdata,
  input  wire logic                       lockdown
);
  import sal_pkg::*;
  localparam logic [12:0] A_TYPE  = {1'b0, OFF_TYPE};
  localparam logic [12:0] A_MASK  = {1'b1, OFF_PRIO_MASK};
  localparam logic [12:0] A_RUN   = {1'b1, OFF_RUN_PRIO};
  localparam logic [12:0] A_ALIAS = {1'b1, OFF_ALIAS_BP};
  logic [7:0] mask_reg;
  logic       rd_ack;
  logic       ns_rd;

  // Read answers, and non-secure ones
  assign rd_ack = ack && !wr;
  assign ns_rd  = rd_ack && !sec;

  // Mask model: secure writes direct, non-secure only through the upper-half view
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      mask_reg <= PMR_RESET;
    else if (ack && wr && addr == A_MASK && (sec || mask_reg[7]))
      mask_reg <= sec ? wdata[7:0] : {1'b1, wdata[7:1]};
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Handshake shape, and lockdown held once raised
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
  property p_ack_follows; req && !ack |=> ack; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not answered");
  property p_no_stray_ack; !req |=> !ack; endproperty
  a_no_stray_ack: assert property (p_no_stray_ack) else $error("ack without request");
  property p_lock_hold; lockdown |=> lockdown; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockdown dropped");
  // Register views
  property p_type_read;
    rd_ack && addr == A_TYPE |-> rdata[TYPE_SEC_POS] && rdata[TYPE_LOCKABLE_COUNT_FIELD_POS +: 5] == LOCKABLE_COUNT_FIELD_NUM[4:0];
  endproperty
  a_type_read: assert property (p_type_read) else $error("type register wrong");
  property p_sec_only; ns_rd && (addr == A_ALIAS || addr[12:7] == 6'h01) |-> rdata == 32'h0;
  endproperty
  a_sec_only: assert property (p_sec_only) else $error("secure-only data leaked");
  property p_prio_view; ns_rd && addr[12:10] == 3'h1 |-> (rdata & 32'h01010101) == 32'h0;
  endproperty
  a_prio_view: assert property (p_prio_view) else $error("priority view not halved");
  property p_mask_view;
    ns_rd && addr == A_MASK |-> rdata == (mask_reg[7] ? {24'h0, mask_reg[6:0], 1'b0} : 32'h0);
  endproperty
  a_mask_view: assert property (p_mask_view) else $error("mask view wrong");
  property p_run_view; ns_rd && addr == A_RUN |-> rdata == (mask_reg[7] ? 32'hfe : 32'h0);
  endproperty
  a_run_view: assert property (p_run_view) else $error("running priority view wrong");

  // Main scenarios reached
  c_lock_write: cover property (ack && wr && sec && lockdown);
  c_ns_mask_high: cover property (ns_rd && addr == A_MASK && mask_reg[7]);
  c_type_read: cover property (rd_ack && addr == A_TYPE);
endmodule

/* File: secure_access_lockdown_tb.sv */
// Bench for the secure access and lockdown front end, both link ends.
// Assumes sal_pkg, sal_if, sal_host, sal_dev and sal_asserts compiled first.
`timescale 1ns/10ps
module secure_access_lockdown_tb;
  import sal_pkg::*;
  localparam int          NIRQ     = 64;
  localparam int          NLSPI    = 31;
  localparam logic [31:0] TYPE_EXP = (NLSPI << TYPE_LOCKABLE_COUNT_FIELD_POS) | (1 << TYPE_SEC_POS) | (NIRQ/32-1);
  localparam logic        S        = 1'b1;
  localparam logic        N        = 1'b0;
  logic        i_clk;
  logic        i_rst;
  logic        i_ce;
  logic [2:0]  av_address;
  logic        av_read;
  logic        av_write;
  logic [31:0] av_writedata;
  logic [31:0] av_readdata;
  logic        av_waitrequest;
  logic [31:0] rv;
  int          n_mismatch = 0;
  int          comparisons = 0;

  // Both ends joined through the link, checker beside it
  sal_if link_if ();
  sal_host sal_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_av_address(av_address), .i_av_read(av_read), .i_av_write(av_write),
    .i_av_writedata(av_writedata), .o_av_readdata(av_readdata),
    .o_av_waitrequest(av_waitrequest), .link(link_if));
  sal_dev #(.NUM_IRQ(NIRQ), .LOCKABLE_COUNT_FIELD_NUM(NLSPI), .FIXED_MSK(64'h1), .FIXED_VAL(64'h1))
    sal_dev_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .link(link_if));
  sal_asserts #(.LOCKABLE_COUNT_FIELD_NUM(NLSPI)) sal_asserts_inst (.i_clk(i_clk), .i_rst(i_rst),
    .req(link_if.req), .wr(link_if.wr), .sec(link_if.sec), .addr(link_if.addr),
    .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata),
    .lockdown(link_if.lockdown));

  // 40 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Hang guard
  initial
  begin
    repeat (6000) @(posedge i_clk);
    n_mismatch++;
    stop_test();
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer, raised just after an edge and held until the rising
  // edge at which waitrequest is sampled low; read data is taken at that edge
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_address   <= a;
    av_write     <= w;
    av_read      <= !w;
    av_writedata <= d;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (av_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      n_mismatch++;
    rv = av_readdata;
    av_read  <= 1'b0;
    av_write <= 1'b0;
    // One idle cycle before the next request
    @(posedge i_clk);
  endtask

  // One link access through the host: address, data, go, poll busy, fetch data
  task automatic acc(input logic w, input logic s, input logic [12:0] a, input logic [31:0] d);
    logic [31:0] c;
    int          n;
    c = 32'h0;
    c[CTRL_WR_POS] = w;
    c[CTRL_SEC_POS] = s;
    c[CTRL_GO_POS] = 1'b1;
    av(1'b1, HOST_ADDR, {19'h0, a});
    av(1'b1, HOST_WDATA, d);
    av(1'b1, HOST_CTRL, c);
    n = 0;
    do
    begin
      av(1'b0, HOST_STATUS, 32'h0);
      n++;
    end
    while (rv[0] !== 1'b0 && n < 20);
    if (n >= 20)
      n_mismatch++;
    av(1'b0, HOST_RDATA, 32'h0);
  endtask

  task automatic wr(input logic s, input logic [12:0] a, input logic [31:0] d);
    acc(1'b1, s, a, d);
  endtask

  task automatic rd(input logic s, input logic [12:0] a, input logic [31:0] e);
    acc(1'b0, s, a, 32'h0);
    chk($sformatf("read %h sec %b", a, s), rv, e);
  endtask

  function automatic logic [12:0] dr(input logic [11:0] o);
    return {1'b0, o};
  endfunction

  function automatic logic [12:0] cr(input logic [11:0] o);
    return {1'b1, o};
  endfunction

  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    av_address = 3'h0;
    av_read = 1'b0;
    av_write = 1'b0;
    av_writedata = 32'h0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(S, dr(OFF_TYPE), TYPE_EXP);
    wr(S, dr(OFF_TYPE), 32'h0);
    rd(N, dr(OFF_TYPE), TYPE_EXP);
    rd(S, dr(OFF_SECURITY), 32'h1);
    wr(S, dr(OFF_SECURITY), 32'hf0);
    wr(N, dr(OFF_SECURITY), 32'hffffffff);
    rd(S, dr(OFF_SECURITY), 32'hf1);
    rd(N, dr(OFF_SECURITY), 32'h0);
    $display("test security done");
    wr(S, dr(OFF_DIST_CTL), 32'h1);
    rd(N, dr(OFF_DIST_CTL), 32'h0);
    wr(N, dr(OFF_DIST_CTL), 32'h1);
    wr(S, dr(OFF_DIST_CTL), 32'h0);
    rd(N, dr(OFF_DIST_CTL), 32'h1);
    wr(S, cr(OFF_CPU_CTL), 32'h1d);
    rd(N, cr(OFF_CPU_CTL), 32'h0);
    wr(N, cr(OFF_CPU_CTL), 32'h1);
    rd(N, cr(OFF_CPU_CTL), 32'h1);
    wr(S, cr(OFF_BIN_POINT), 32'h5);
    wr(N, cr(OFF_BIN_POINT), 32'h2);
    rd(S, cr(OFF_BIN_POINT), 32'h5);
    rd(S, cr(OFF_ALIAS_BP), 32'h2);
    rd(N, cr(OFF_ALIAS_BP), 32'h0);
    wr(N, cr(OFF_ALIAS_BP), 32'h7);
    rd(N, cr(OFF_BIN_POINT), 32'h2);
    $display("test banking done");
    wr(S, dr(OFF_PRIO + 12'h4), 32'h80402010);
    wr(N, dr(OFF_PRIO + 12'h4), 32'hffffffff);
    rd(N, dr(OFF_PRIO + 12'h4), 32'h0);
    rd(S, dr(OFF_PRIO + 12'h4), 32'h80402010);
    wr(S, dr(OFF_PRIO + 12'h8), 32'h80402010);
    rd(N, dr(OFF_PRIO + 12'h8), 32'h00804020);
    wr(N, dr(OFF_PRIO + 12'h8), 32'h204060fe);
    rd(S, dr(OFF_PRIO + 12'h8), 32'h90a0b0ff);
    wr(S, dr(OFF_SET_EN), 32'h110);
    rd(N, dr(OFF_SET_EN), 32'h100);
    wr(N, dr(OFF_CLR_EN), 32'h110);
    rd(S, dr(OFF_SET_EN), 32'h10);
    rd(N, cr(OFF_RUN_PRIO), 32'h0);
    wr(N, cr(OFF_PRIO_MASK), 32'hfe);
    rd(S, cr(OFF_PRIO_MASK), 32'h0);
    wr(S, cr(OFF_PRIO_MASK), 32'h7f);
    rd(N, cr(OFF_PRIO_MASK), 32'h0);
    wr(S, cr(OFF_PRIO_MASK), 32'h80);
    rd(N, cr(OFF_RUN_PRIO), 32'hfe);
    wr(N, cr(OFF_PRIO_MASK), 32'h10);
    rd(S, cr(OFF_PRIO_MASK), 32'h88);
    rd(N, cr(OFF_PRIO_MASK), 32'h10);
    rd(S, cr(OFF_RUN_PRIO), 32'hff);
    $display("test priority done");
    wr(S, dr(OFF_SECURITY + 12'h4), 32'hc000000f);
    wr(S, dr(OFF_PRIO + 12'h20), 32'h11223344);
    av(1'b0, HOST_ADDR, 32'h0);
    chk("host addr", rv, 32'h420);
    av(1'b0, HOST_WDATA, 32'h0);
    chk("host wdata", rv, 32'h11223344);
    av(1'b1, HOST_CTRL, 32'h1 << CTRL_LOCK_POS);
    av(1'b0, HOST_STATUS, 32'h0);
    chk("status lockdown", {31'h0, rv[1]}, 32'h1);
    chk("link lockdown", {31'h0, link_if.lockdown}, 32'h1);
    wr(S, dr(OFF_DIST_CTL), 32'h1);
    rd(S, dr(OFF_DIST_CTL), 32'h0);
    wr(S, cr(OFF_CPU_CTL), 32'h2);
    rd(S, cr(OFF_CPU_CTL), 32'h1f);
    wr(S, cr(OFF_CPU_CTL), 32'h0);
    rd(S, cr(OFF_CPU_CTL), 32'h1d);
    wr(S, dr(OFF_PRIO + 12'h20), 32'h0);
    rd(S, dr(OFF_PRIO + 12'h20), 32'h11223344);
    wr(S, dr(OFF_SET_EN + 12'h4), 32'hc0000000);
    rd(S, dr(OFF_SET_EN + 12'h4), 32'h80000000);
    wr(S, dr(OFF_SECURITY + 12'h4), 32'h0);
    rd(S, dr(OFF_SECURITY + 12'h4), 32'h4000000f);
    wr(S, dr(OFF_SECURITY + 12'h4), 32'h4000001f);
    wr(S, dr(OFF_SECURITY + 12'h4), 32'h0);
    rd(S, dr(OFF_SECURITY + 12'h4), 32'h4000001f);
    $display("test lockdown done");
    // Clock enable low freezes the bus answer; the write lands once it returns
    i_ce <= 1'b0;
    fork
      av(1'b1, HOST_WDATA, 32'h5a5a5a5a);
      begin
        repeat (4) @(posedge i_clk);
        chk("frozen waitrequest", {31'h0, av_waitrequest}, 32'h1);
        i_ce <= 1'b1;
      end
    join
    av(1'b0, HOST_WDATA, 32'h0);
    chk("host wdata after freeze", rv, 32'h5a5a5a5a);
    $display("test freeze done");
    stop_test();
  end
endmodule
